// *** core/hdm_pkg.sv ***
/*
  Shared constants for the host DMA handshake engine: register byte
  addresses, field positions, reset values, handshake timing and the
  engine state encoding.
  Assumes a 24-bit byte address from the register port and a 250 MHz clock.
*/
package hdm_pkg;

  // Register byte addresses as seen on the register port
  localparam logic [23:0] OFF_IRQ_MASK = 24'hFF_8403;
  localparam logic [23:0] OFF_ADDR_UPPER = 24'hFF_8404;
  localparam logic [23:0] OFF_CONTROL = 24'hFF_8405;
  localparam logic [23:0] OFF_COUNT_HIGH = 24'hFF_8406;
  localparam logic [23:0] OFF_COUNT_LOW = 24'hFF_8407;
  localparam logic [23:0] OFF_ADDR_MID = 24'hFF_8408;
  localparam logic [23:0] OFF_ADDR_LOW = 24'hFF_8409;
  localparam logic [23:0] OFF_DATA_WORD = 24'hFF_840A;
  localparam logic [23:0] OFF_DATA_LOW = 24'hFF_840B;
  localparam logic [23:0] OFF_LINE_CFG = 24'hFF_840C;
  localparam logic [23:0] OFF_STATUS = 24'hFF_840D;
  localparam logic [23:0] OFF_IRQ_CLEAR = 24'hFF_840E;

  // Interrupt source positions, shared by mask, status and clear; the active bit is status only
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TX_WORD_BIT = 3;
  localparam int IRQ_RX_WORD_BIT = 6;
  localparam int STAT_ACTIVE_BIT = 7;

  // Control byte fields
  localparam int CTRL_TO_HOST_BIT = 0;
  localparam int CTRL_CYC_A_BIT = 1;
  localparam int CTRL_CYC_B_BIT = 2;
  localparam int CTRL_REQ_LOW_BIT = 3;
  localparam int CTRL_BUSY_LOW_BIT = 4;

  // Long-line configuration: enable bit and delay field width
  localparam int LINE_EN_BIT = 7;
  localparam int DLY_W = 7;

  // Values after reset
  localparam logic [7:0] IRQ_MASK_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LINE_CFG_RST = 8'h00;

  // Handshake timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LL_MIN_NS = 70;
  localparam int LL_MAX_NS = 280;
  localparam logic [DLY_W-1:0] LL_MIN_CYC =
    DLY_W'((LL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] LL_MAX_CYC = DLY_W'(LL_MAX_NS / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] SHORT_SETUP_CYC = 7'h01;

  // Engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ARMED = 6'b00_0010,
    ST_SETUP = 6'b00_0100,
    ST_REQ = 6'b00_1000,
    ST_BUSY = 6'b01_0000,
    ST_SETTLE = 6'b10_0000
  } hdm_state_t;

endpackage

// *** core/hdm_dma_engine.sv ***
/*
  Host DMA handshake engine: register file, word buffers, request/busy
  handshake toward the host DMA interface, and the interrupt.
  Assumes the register master keeps the one-cycle strobe protocol, and
  that every host pin is asynchronous to ref_clk_i.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module hdm_dma_engine
  import hdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o,
  input wire logic host_ready_n_i,
  input wire logic host_busy_i,
  input wire logic [15:0] host_data_i,
  output logic xfer_req_o,
  output logic [15:0] host_data_o,
  output logic host_cycle_type_bit_a_o,
  output logic host_cycle_type_bit_b_o,
  output logic transfer_stop_flag_o,
  output logic [22:0] dma_addr_o
);

  hdm_state_t state;
  logic [7:0] irq_mask;
  logic [7:0] dma_control;
  logic [7:0] line_cfg;
  logic [22:0] dma_addr;
  logic [15:0] xfer_count;
  logic [15:0] tx_buf;
  logic tx_full;
  logic [15:0] rx_buf;
  logic rx_full;
  logic [7:0] irq_status;
  logic [DLY_W-1:0] dly;
  logic busy_s1, busy_s2, busy_prev;
  logic ready_s1, ready_s2;
  logic [15:0] din_s1, din_s2;

  // Decoded strobes
  logic wr_upper, wr_ctrl, wr_cnt_hi, wr_cnt_lo, wr_mid, wr_low;
  logic wr_data_hi, wr_data_lo, wr_mask, wr_line, wr_clear;
  logic rd_status, rd_data;
  assign wr_upper = reg_wr_i && (reg_addr_i == OFF_ADDR_UPPER);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CONTROL);
  assign wr_cnt_hi = reg_wr_i && (reg_addr_i == OFF_COUNT_HIGH);
  assign wr_cnt_lo = reg_wr_i && (reg_addr_i == OFF_COUNT_LOW);
  assign wr_mid = reg_wr_i && (reg_addr_i == OFF_ADDR_MID);
  assign wr_low = reg_wr_i && (reg_addr_i == OFF_ADDR_LOW);
  assign wr_data_hi = reg_wr_i && (reg_addr_i == OFF_DATA_WORD);
  assign wr_data_lo = reg_wr_i && (reg_addr_i == OFF_DATA_LOW);
  assign wr_mask = reg_wr_i && (reg_addr_i == OFF_IRQ_MASK);
  assign wr_line = reg_wr_i && (reg_addr_i == OFF_LINE_CFG);
  assign wr_clear = reg_wr_i && (reg_addr_i == OFF_IRQ_CLEAR);
  assign rd_status = reg_rd_i && (reg_addr_i == OFF_STATUS);
  assign rd_data = reg_rd_i && (reg_addr_i == OFF_DATA_WORD);

  // Host-side levels with busy's configured polarity and ready's fixed active-low polarity folded out
  logic to_host, busy_act, busy_fell, ready_act, line_en;
  assign to_host = dma_control[CTRL_TO_HOST_BIT];
  assign busy_act = busy_s2 ^ dma_control[CTRL_BUSY_LOW_BIT];
  assign busy_fell = busy_prev && !busy_act;
  assign ready_act = !ready_s2;
  assign line_en = line_cfg[LINE_EN_BIT];

  // Long-line delay, clamped into the window the extender can realise
  logic [DLY_W-1:0] line_dly, setup_dly;
  always_comb begin
    line_dly = line_cfg[DLY_W-1:0];
    if (line_dly < LL_MIN_CYC) begin
      line_dly = LL_MIN_CYC;
    end else if (line_dly > LL_MAX_CYC) begin
      line_dly = LL_MAX_CYC;
    end
    setup_dly = line_en ? line_dly : SHORT_SETUP_CYC;
  end

  // Word-level conditions of the handshake
  logic buf_ok, word_done, next_zero;
  logic [15:0] next_count;
  assign buf_ok = to_host ? tx_full : !rx_full;
  assign next_count = xfer_count + 16'h0001;
  assign next_zero = (next_count == 16'h0000);
  assign word_done = ((state == ST_BUSY) && busy_fell && !line_en) ||
                     ((state == ST_SETTLE) && (dly == '0));

  // Two-flop synchronisers on every host pin; data shares busy's latency
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      ready_s1 <= 1'b1;
      ready_s2 <= 1'b1;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end else begin
      busy_s1 <= host_busy_i;
      busy_s2 <= busy_s1;
      ready_s1 <= host_ready_n_i;
      ready_s2 <= ready_s1;
      din_s1 <= host_data_i;
      din_s2 <= din_s1;
    end
  end

  // Previous active busy level for trailing-edge detection
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_prev <= 1'b0;
    end else begin
      busy_prev <= busy_act;
    end
  end

  // Handshake sequencer; the host never starts a cycle, only answers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      dly <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (wr_upper) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          // Zero count means nothing to move; finish without a request
          if (ready_act) begin
            state <= (xfer_count == 16'h0000) ? ST_IDLE : ST_SETUP;
            dly <= setup_dly;
          end
        end
        ST_SETUP: begin
          // Hold off until a word is loaded (to host) or the receive buffer is free, and busy has gone idle
          if (!buf_ok || busy_act) begin
            dly <= setup_dly;
          end else if (dly > SHORT_SETUP_CYC) begin
            dly <= dly - SHORT_SETUP_CYC;
          end else begin
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (busy_act) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (busy_fell) begin
            if (line_en) begin
              state <= ST_SETTLE;
              dly <= line_dly;
            end else begin
              state <= next_zero ? ST_IDLE : ST_SETUP;
              dly <= setup_dly;
            end
          end
        end
        ST_SETTLE: begin
          if (dly == '0) begin
            state <= next_zero ? ST_IDLE : ST_SETUP;
            dly <= setup_dly;
          end else begin
            dly <= dly - SHORT_SETUP_CYC;
          end
        end
      endcase
    end
  end

  // Software configuration registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask <= IRQ_MASK_RST;
      dma_control <= CTRL_RST;
      line_cfg <= LINE_CFG_RST;
    end else begin
      if (wr_mask) begin
        irq_mask <= reg_wdata_i[7:0];
      end
      // Control changes are ignored mid-transfer so polarity cannot flip
      if (wr_ctrl && (state == ST_IDLE)) begin
        dma_control <= reg_wdata_i[7:0];
      end
      if (wr_line) begin
        line_cfg <= reg_wdata_i[7:0];
      end
    end
  end

  // Address and count: loaded by software, advanced once per word
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_addr <= 23'h00_0000;
      xfer_count <= 16'h0000;
    end else if (word_done) begin
      dma_addr <= dma_addr + 23'h00_0001;
      xfer_count <= next_count;
    end else if (state == ST_IDLE) begin
      if (wr_upper) begin
        dma_addr[22:16] <= reg_wdata_i[6:0];
      end
      if (wr_mid) begin
        dma_addr[15:8] <= reg_wdata_i[7:0];
      end
      if (wr_low) begin
        dma_addr[7:0] <= reg_wdata_i[7:0];
      end
      if (wr_cnt_hi) begin
        xfer_count[15:8] <= reg_wdata_i[7:0];
      end
      if (wr_cnt_lo) begin
        xfer_count[7:0] <= reg_wdata_i[7:0];
      end
    end
  end

  // Outgoing word: high byte first, the low byte completes it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_buf <= 16'h0000;
      tx_full <= 1'b0;
    end else begin
      if (wr_data_hi) begin
        tx_buf[15:8] <= reg_wdata_i[7:0];
      end
      if (wr_data_lo) begin
        tx_buf[7:0] <= reg_wdata_i[7:0];
      end
      // A new low byte wins over the word just handed to the host
      if (wr_data_lo) begin
        tx_full <= 1'b1;
      end else if (word_done && to_host) begin
        tx_full <= 1'b0;
      end
    end
  end

  // Incoming word, held until software reads the data register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_buf <= 16'h0000;
      rx_full <= 1'b0;
    end else begin
      if (word_done && !to_host) begin
        rx_buf <= din_s2;
        rx_full <= 1'b1;
      end else if (rd_data) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Sticky event bits; a set in the clearing cycle is kept
  logic [7:0] irq_set, irq_clr;
  always_comb begin
    irq_set = 8'h00;
    irq_set[IRQ_DONE_BIT] = word_done && next_zero;
    irq_set[IRQ_TX_WORD_BIT] = word_done && to_host;
    irq_set[IRQ_RX_WORD_BIT] = word_done && !to_host;
    irq_clr = wr_clear ? reg_wdata_i[7:0] : 8'h00;
    irq_clr[IRQ_DONE_BIT] = irq_clr[IRQ_DONE_BIT] || rd_status;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // Interrupt: any source whose mask bit is clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_status & ~irq_clr) | irq_set) & ~irq_mask);
    end
  end

  // Host-facing outputs, all registered
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xfer_req_o <= 1'b0;
      host_data_o <= 16'h0000;
      host_cycle_type_bit_a_o <= 1'b0;
      host_cycle_type_bit_b_o <= 1'b0;
      transfer_stop_flag_o <= 1'b0;
      dma_addr_o <= 23'h00_0000;
    end else begin
      // Request active only in its own state; idle level follows polarity
      xfer_req_o <= (state == ST_REQ) ^ dma_control[CTRL_REQ_LOW_BIT];
      // Data is refreshed every to-host setup cycle, the last time a cycle before request
      if ((state == ST_SETUP) && to_host) begin
        host_data_o <= tx_buf;
      end
      host_cycle_type_bit_a_o <= dma_control[CTRL_CYC_A_BIT];
      host_cycle_type_bit_b_o <= dma_control[CTRL_CYC_B_BIT];
      // Attention rises at the last word, or at once for a zero count, and falls at the next start
      if (word_done && next_zero) begin
        transfer_stop_flag_o <= 1'b1;
      end else if ((state == ST_ARMED) && ready_act &&
                   (xfer_count == 16'h0000)) begin
        transfer_stop_flag_o <= 1'b1;
      end else if (wr_upper && (state == ST_IDLE)) begin
        transfer_stop_flag_o <= 1'b0;
      end
      dma_addr_o <= dma_addr;
    end
  end

  // Read data, valid the cycle after the strobe; write-only reads zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == OFF_IRQ_MASK) begin
        reg_rdata_o <= {8'h00, irq_mask};
      end else if (reg_addr_i == OFF_DATA_WORD) begin
        reg_rdata_o <= rx_buf;
      end else if (reg_addr_i == OFF_STATUS) begin
        reg_rdata_o <= {8'h00, (state != ST_IDLE), irq_status[6:0]};
      end else if (reg_addr_i == OFF_LINE_CFG) begin
        reg_rdata_o <= {8'h00, line_cfg};
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule

// *** dv/hdm_dma_engine_assertions.sv ***
/*
  Port checker for the host DMA engine.
  Assumes request and busy stay active high and ready stays low once raised.
*/
`timescale 1ns/1ps
module hdm_dma_engine_assertions
  import hdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic host_ready_n_i,
  input wire logic host_busy_i,
  input wire logic [15:0] host_data_i,
  input wire logic xfer_req_o,
  input wire logic [15:0] host_data_o,
  input wire logic host_cycle_type_bit_a_o,
  input wire logic host_cycle_type_bit_b_o,
  input wire logic transfer_stop_flag_o,
  input wire logic [22:0] dma_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Start strobe, the only thing that may end the stop flag
  wire logic wr_upper = reg_wr_i && (reg_addr_i == OFF_ADDR_UPPER);

  // Handshake steps
  sequence req_start; $rose(xfer_req_o); endsequence
  sequence req_drops; ##[1:5] !xfer_req_o; endsequence

  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  req_idle_a: assert property (req_start |-> !host_busy_i && !$past(host_busy_i))
    else $error("request rose while busy active");
  busy_block_a: assert property (host_busy_i && !xfer_req_o |=> !xfer_req_o)
    else $error("request rose during busy");
  req_drop_a: assert property ($rose(host_busy_i) |-> req_drops)
    else $error("request held after busy");
  req_hold_a: assert property (req_start |=> xfer_req_o [*2])
    else $error("request withdrawn before busy");
  req_gap_a: assert property ($fell(host_busy_i) |-> !xfer_req_o [*3])
    else $error("request too soon after busy ended");
  data_stable_a: assert property (xfer_req_o |-> $stable(host_data_o))
    else $error("outgoing data moved during request");
  stop_idle_a: assert property (transfer_stop_flag_o |-> !xfer_req_o)
    else $error("request while stop flag high");
  stop_fall_a: assert property ($fell(transfer_stop_flag_o) |->
    $past(wr_upper) || $past(wr_upper, 2) || $past(wr_upper, 3) || $past(wr_upper, 4))
    else $error("stop flag ended without a start write");
  cyc_change_a: assert property ($changed(host_cycle_type_bit_a_o) ||
    $changed(host_cycle_type_bit_b_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("cycle type lines changed without a write");
  ready_gate_a: assert property (req_start |-> !$past(host_ready_n_i, 3))
    else $error("request before ready");
endmodule

// *** dv/hdm_host_model.sv ***
/*
  Host DMA interface model: answers each request with busy after a delay.
  Assumes request and busy active high; data held two edges after busy ends.
*/
`timescale 1ns/1ps
module hdm_host_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic [15:0] data_i,
  input wire logic [3:0] delay_i,
  input wire logic [15:0] word_i,
  output logic busy_o,
  output logic [15:0] data_o,
  output logic [15:0] seen_o
);
  logic [3:0] cnt;
  logic hold;

  // Busy only ever follows a request, so the host never starts a cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      cnt <= 4'h0;
      hold <= 1'b0;
      data_o <= 16'h0000;
      seen_o <= 16'h0000;
    end else if (!busy_o && req_i) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay_i) begin
        busy_o <= 1'b1;
        cnt <= 4'h0;
        seen_o <= data_i;
        data_o <= word_i;
      end
    end else if (busy_o && !req_i) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay_i) begin
        busy_o <= 1'b0;
        cnt <= 4'h0;
        hold <= 1'b1;
      end
    end else if (!busy_o) begin
      // Released lines toggle so a late capture sees the old word only on alternate cycles
      hold <= 1'b0;
      if (!hold) data_o <= ~data_o;
    end
  end
endmodule

// *** dv/hdm_dma_engine_test.sv ***
/*
  Bench for the host DMA engine: register tasks, host model and tests.
  Assumes the checker and host model are compiled before this file.
*/
`timescale 1ns/1ps
module hdm_dma_engine_test;
  import hdm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [23:0] addr = 24'h00_0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rdy_n = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [15:0] word = 16'hBEEF;
  logic [15:0] rdata, hdin, hdout, seen, v;
  logic irq, busy, req, cta, ctb, stop;
  logic [22:0] daddr;
  int num_errors = 0;
  int cmp_count = 0;
  int nreq = 0;

  // 250 MHz clock and a count of request pulses
  always #2 clk = ~clk;
  always @(posedge req) nreq = nreq + 1;

  hdm_dma_engine hdm_dma_engine_i (.ref_clk_i(clk), .resetn_i(resetn),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .irq_o(irq), .host_ready_n_i(rdy_n), .host_busy_i(busy),
    .host_data_i(hdin), .xfer_req_o(req), .host_data_o(hdout),
    .host_cycle_type_bit_a_o(cta), .host_cycle_type_bit_b_o(ctb),
    .transfer_stop_flag_o(stop), .dma_addr_o(daddr));

  hdm_host_model hdm_host_model_i (.clk_i(clk), .resetn_i(resetn), .req_i(req),
    .data_i(hdout), .delay_i(dly), .word_i(word), .busy_o(busy), .data_o(hdin),
    .seen_o(seen));

  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle strobes; a gap cycle keeps each strobe to one assignment per step
  task automatic wrt(input logic [23:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // The answer stands only in the cycle after the strobe, so look mid-cycle
  task automatic rdt(input logic [23:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic load(input logic [15:0] w);
    wrt(OFF_DATA_WORD, {8'h00, w[15:8]});
    wrt(OFF_DATA_LOW, {8'h00, w[7:0]});
  endtask

  // Bounded waits on status polling and on the stop flag
  task automatic poll(input int b);
    int n;
    n = 0;
    v = 16'h0000;
    while (v[b] !== 1'b1 && n < 200) begin
      rdt(OFF_STATUS, v);
      n++;
    end
    chk("status poll", 1, v[b]);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (stop === 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    while (stop !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("stop flag", 1, stop);
    // The address output trails the stop flag by one register stage
    repeat (2) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well past the expected few hundred cycles
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdt(OFF_IRQ_MASK, v); chk("mask reset", 16'h00FF, v);
    rdt(24'hFF_8401, v); chk("unmapped read", 16'h0000, v);
    wrt(24'hFF_8401, 16'h0000);
    wrt(OFF_IRQ_MASK, 16'h00FE);
    rdt(OFF_IRQ_MASK, v); chk("mask", 16'h00FE, v);
    rdt(OFF_STATUS, v); chk("status reset", 16'h0000, v);
    $display("test regs done");
    // Two words to the host, started before ready
    wrt(OFF_COUNT_HIGH, 16'h00FF);
    wrt(OFF_COUNT_LOW, 16'h00FE);
    wrt(OFF_ADDR_MID, 16'h0012);
    wrt(OFF_ADDR_LOW, 16'h0034);
    wrt(OFF_CONTROL, 16'h0001);
    load(16'hA55A);
    wrt(OFF_ADDR_UPPER, 16'h0005);
    repeat (20) @(posedge clk);
    chk("request before ready", 0, nreq);
    rdy_n <= 1'b0;
    poll(IRQ_TX_WORD_BIT); chk("first word", 16'hA55A, seen);
    load(16'h3CC3);
    wait_done(); chk("second word", 16'h3CC3, seen);
    chk("requests", 2, nreq);
    chk("word address", 23'h05_1236, daddr);
    chk("done irq", 1, irq);
    rdt(OFF_STATUS, v); chk("status", 16'h0009, v);
    @(posedge clk); chk("irq after read", 0, irq);
    rdt(OFF_STATUS, v); chk("status after read", 16'h0008, v);
    $display("test to_host done");
    // One word from a slow host, done masked then unmasked
    wrt(OFF_IRQ_CLEAR, 16'h00FF);
    wrt(OFF_IRQ_MASK, 16'h00FF);
    dly <= 4'h3;
    wrt(OFF_COUNT_HIGH, 16'h00FF);
    wrt(OFF_COUNT_LOW, 16'h00FF);
    wrt(OFF_CONTROL, 16'h0006);
    wrt(OFF_ADDR_UPPER, 16'h0000);
    chk("cycle type", 2'b11, {cta, ctb});
    wait_done();
    chk("masked irq", 0, irq);
    rdt(OFF_DATA_WORD, v); chk("rx word", 16'hBEEF, v);
    wrt(OFF_IRQ_MASK, 16'h00FE);
    @(posedge clk); chk("unmasked irq", 1, irq);
    rdt(OFF_STATUS, v); chk("rx status", 16'h0041, v);
    $display("test from_host done");
    // Zero count ends without any request
    wrt(OFF_COUNT_HIGH, 16'h0000);
    wrt(OFF_COUNT_LOW, 16'h0000);
    wrt(OFF_ADDR_UPPER, 16'h0000);
    wait_done();
    chk("zero count requests", 3, nreq);
    $display("test zero_count done");
    // One word to the host with the long-line delay, below-range delay clamped
    wrt(OFF_LINE_CFG, 16'h0085);
    rdt(OFF_LINE_CFG, v); chk("line cfg", 16'h0085, v);
    wrt(OFF_COUNT_HIGH, 16'h00FF);
    wrt(OFF_COUNT_LOW, 16'h00FF);
    wrt(OFF_CONTROL, 16'h0001);
    load(16'h5AA5);
    wrt(OFF_ADDR_UPPER, 16'h0000);
    wait_done(); chk("long line word", 16'h5AA5, seen);
    chk("long line requests", 4, nreq);
    $display("test long_line done");
    stop_test();
  end
endmodule

bind hdm_dma_engine hdm_dma_engine_assertions hdm_dma_engine_assertions_i (.*);
